// file: logic/ssc_engine.sv
// security command engine: erase prepare/unit, freeze lock, set password, unlock
`timescale 1ns/1ps
// How it works
// - erase unit aborted without preceding erase prepare
// - erase unit aborted on password mismatch
// - frozen rejects set, unlock, disable, erase
// - only hardware or power reset unfreezes
// - freeze while frozen succeeds, stays frozen
// - freeze completion writes zero sector count
// - without security support freeze means wear-level
// - set password takes one data sector
// - word0 bit0 identifier, bit8 level, words1-16 password
// - user high: lock at reset, both unlock
// - user maximum: lock at reset, user only
// - master set keeps lock and level
// - master unlock: compare high, reject maximum
// - user unlock compares stored user password
// - locked mismatch aborts, decrements counter from five
// - counter zero aborts unlock and erase
// - unlock while unlocked leaves counter alone
// - erase/unlock sector bit0 selects compare password
module ssc_engine import ssc_pkg::*; #(
   parameter int SECTOR_WORDS_P = SECTOR_WORDS
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic hw_rst_n_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic we_i,
   input wire logic re_i,
   output logic [DATA_W-1:0] rdata_o,
   output logic busy_o,
   output logic drq_o,
   output logic locked_o,
   output logic frozen_o,
   output logic erase_o,
   output logic wear_level_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // declarations
   localparam int PW_BITS = PW_WORDS * DATA_W;
   localparam logic [8:0] LAST_WORD = 9'(SECTOR_WORDS_P - 1);

   logic hw_meta;
   logic hw_sync;
   ssc_state_t state;
   ssc_state_t next_state;
   ssc_cmd_t cmd;
   ssc_sec_t sec;
   ssc_sec_t next_sec;
   logic last_prep;
   logic err;
   logic [DATA_W-1:0] seccnt;
   logic [DATA_W-1:0] config_r;
   logic [8:0] word_cnt;
   logic [8:0] pw_idx;
   logic [PW_WORDS-1:0][DATA_W-1:0] pw_buf;
   logic user_match;
   logic master_match;
   logic cmd_wr;
   logic data_wr;
   logic last_data;
   logic [7:0] op_in;
   logic is_sec_op;
   logic pre_rej;
   logic exec_done;
   logic pw_ok;
   logic max_rej;
   logic unlock_mis;
   logic exec_abort;
   logic exec_ok;
   logic load_user;
   logic load_master;
   logic [DATA_W-1:0] stat_word;
   logic [DATA_W-1:0] sec_word;

   if (SECTOR_WORDS_P < PW_FIRST_WORD + PW_WORDS || SECTOR_WORDS_P > 512) begin : g_chk
      $error("ssc_engine: sector length cannot hold the password");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // hardware reset pin: two flops before anything looks at it
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hw_meta <= 1'b0;
         hw_sync <= 1'b0;
      end else begin
         hw_meta <= hw_rst_n_i;
         hw_sync <= hw_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // bus decode; commands written while busy are dropped
   assign cmd_wr = we_i && (addr_i == ADDR_CMD_STAT) && (state == ST_IDLE) && hw_sync;
   assign data_wr = we_i && (addr_i == ADDR_DATA) && (state == ST_XFER);
   assign last_data = data_wr && (word_cnt == LAST_WORD);
   assign op_in = wdata_i[7:0];
   assign is_sec_op = (op_in >= OP_SET_PW) && (op_in <= OP_DISABLE_PW);
   assign exec_done = (state == ST_EXEC);

   // rejections decided before any data moves, so a command refused here never asks for a sector
   always_comb begin
      pre_rej = 1'b0;
      if (!is_sec_op) begin
         pre_rej = 1'b1;
      end else if (!config_r[CFG_SEC_BIT] && op_in != OP_FREEZE) begin
         pre_rej = 1'b1;
      end else if (sec.frozen && op_in != OP_FREEZE && op_in != OP_ERASE_PREP) begin
         pre_rej = 1'b1;
      end else if (op_in == OP_ERASE_UNIT && !last_prep) begin
         pre_rej = 1'b1;
      end else if (sec.tries == 3'h0 && (op_in == OP_UNLOCK || op_in == OP_ERASE_UNIT)) begin
         pre_rej = 1'b1;
      end else if (op_in == OP_DISABLE_PW) begin
         pre_rej = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sequencer: idle, sector transfer, one execute cycle
   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (cmd_wr) begin
               if (!pre_rej && (op_in == OP_SET_PW || op_in == OP_UNLOCK ||
                                op_in == OP_ERASE_UNIT)) begin
                  next_state = ST_XFER;
               end else begin
                  next_state = ST_EXEC;
               end
            end
         end
         ST_XFER: begin
            if (last_data) begin
               next_state = ST_EXEC;
            end
         end
         ST_EXEC: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      if (!hw_sync) begin
         next_state = ST_IDLE;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= ST_IDLE;
         busy_o <= 1'b0;
         drq_o <= 1'b0;
      end else begin
         state <= next_state;
         busy_o <= (next_state != ST_IDLE);
         drq_o <= (next_state == ST_XFER);
      end
   end

   // command latch; identifier and level come from sector word 0
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cmd <= CMD_RESET;
      end else if (cmd_wr) begin
         cmd.op <= op_in;
         cmd.rej <= pre_rej;
         cmd.wear <= !config_r[CFG_SEC_BIT];
         cmd.id_master <= 1'b0;
         cmd.level_max <= 1'b0;
      end else if (data_wr && word_cnt == 9'h000) begin
         cmd.id_master <= wdata_i[CTRL_ID_BIT];
         cmd.level_max <= wdata_i[CTRL_LEVEL_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sector capture: only words 1-16 are kept, the reserved rest is swallowed
   assign pw_idx = word_cnt - 9'(PW_FIRST_WORD);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         word_cnt <= 9'h000;
      end else if (cmd_wr || last_data) begin
         word_cnt <= 9'h000;
      end else if (data_wr) begin
         word_cnt <= word_cnt + 9'h001;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pw_buf <= '0;
      end else if (data_wr && word_cnt >= 9'(PW_FIRST_WORD) &&
                   word_cnt < 9'(PW_FIRST_WORD + PW_WORDS)) begin
         pw_buf[pw_idx[3:0]] <= wdata_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // stored passwords
   assign load_user = exec_ok && cmd.op == OP_SET_PW && !cmd.id_master;
   assign load_master = exec_ok && cmd.op == OP_SET_PW && cmd.id_master;

   ssc_pw_slot #(.PW_BITS(PW_BITS)) u_user_pw (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .load_i(load_user),
      .pw_i(pw_buf),
      .match_o(user_match)
   );

   ssc_pw_slot #(.PW_BITS(PW_BITS)) u_master_pw (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .load_i(load_master),
      .pw_i(pw_buf),
      .match_o(master_match)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // execute decision
   assign pw_ok = cmd.id_master ? master_match : user_match;
   assign max_rej = cmd.id_master && sec.level_max &&
                    (cmd.op == OP_UNLOCK || cmd.op == OP_ERASE_UNIT);
   assign unlock_mis = cmd.op == OP_UNLOCK && sec.locked && !max_rej && !pw_ok;
   assign exec_abort = cmd.rej || max_rej || unlock_mis ||
                       (cmd.op == OP_ERASE_UNIT && !pw_ok);
   assign exec_ok = exec_done && !exec_abort;

   // security state; hardware reset relocks when a user password is armed
   always_comb begin
      next_sec = sec;
      if (exec_done && !cmd.rej && unlock_mis) begin
         next_sec.tries = sec.tries - 3'h1;
      end
      if (exec_ok) begin
         unique case (cmd.op)
            OP_SET_PW: begin
               if (!cmd.id_master) begin
                  next_sec.lock_en = 1'b1;
                  next_sec.level_max = cmd.level_max;
               end
            end
            OP_UNLOCK: begin
               next_sec.locked = 1'b0;
            end
            OP_ERASE_UNIT: begin
               next_sec.locked = 1'b0;
               next_sec.lock_en = 1'b0;
               next_sec.level_max = 1'b0;
            end
            OP_FREEZE: begin
               if (!cmd.wear) begin
                  next_sec.frozen = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
      if (!hw_sync) begin
         next_sec.frozen = 1'b0;
         next_sec.tries = UNLOCK_TRIES;
         next_sec.locked = sec.lock_en;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sec <= SEC_RESET;
         locked_o <= 1'b0;
         frozen_o <= 1'b0;
      end else begin
         sec <= next_sec;
         locked_o <= next_sec.locked;
         frozen_o <= next_sec.frozen;
      end
   end

   // the very next completed command must be the erase unit, anything else disarms it
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         last_prep <= 1'b0;
      end else if (!hw_sync) begin
         last_prep <= 1'b0;
      end else if (exec_done) begin
         last_prep <= exec_ok && cmd.op == OP_ERASE_PREP;
      end
   end

   // one-cycle pulses for the media erase and wear-level engines
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         erase_o <= 1'b0;
         wear_level_o <= 1'b0;
      end else begin
         erase_o <= exec_ok && cmd.op == OP_ERASE_UNIT;
         wear_level_o <= exec_ok && cmd.op == OP_FREEZE && cmd.wear;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // error flag: cleared when a command is taken, set on abort
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         err <= 1'b0;
      end else if (exec_done) begin
         err <= exec_abort;
      end else if (cmd_wr) begin
         err <= 1'b0;
      end
   end

   // sector count: host writes it freely, freeze completion zeroes it
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         seccnt <= SECCNT_RESET;
      end else if (exec_ok && cmd.op == OP_FREEZE && !cmd.wear) begin
         seccnt <= '0;
      end else if (we_i && addr_i == ADDR_SECCNT) begin
         seccnt <= wdata_i;
      end
   end

   // config: security feature support switch
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         config_r <= CONFIG_RESET;
      end else if (we_i && addr_i == ADDR_CONFIG) begin
         config_r <= wdata_i & 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read path: data stand only in the cycle after the strobe
   always_comb begin
      stat_word = '0;
      stat_word[STAT_BSY] = (state != ST_IDLE);
      stat_word[STAT_DRDY] = (state == ST_IDLE);
      stat_word[STAT_DRQ] = (state == ST_XFER);
      stat_word[STAT_ERR] = err;
      sec_word = {9'h000, sec};
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= '0;
      end else if (!re_i) begin
         rdata_o <= '0;
      end else begin
         unique case (addr_i)
            ADDR_SECCNT: rdata_o <= seccnt;
            ADDR_CMD_STAT: rdata_o <= stat_word;
            ADDR_ERROR: rdata_o <= {13'h0000, err, 2'h0};
            ADDR_SECSTATE: rdata_o <= sec_word;
            ADDR_CONFIG: rdata_o <= config_r;
            default: rdata_o <= '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // assertions
   logic take_freeze;
   assign take_freeze = cmd_wr && op_in == OP_FREEZE && config_r[CFG_SEC_BIT];

   AST_ERASE_NEEDS_PREP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (cmd_wr && op_in == OP_ERASE_UNIT && !last_prep) ##1 hw_sync |=> err && !erase_o)
      else $error("erase unit without prepare was not aborted");
   AST_ERASE_MISMATCH: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (exec_done && cmd.op == OP_ERASE_UNIT && !pw_ok) |=> err && !erase_o)
      else $error("erase unit with wrong password completed");
   AST_FROZEN_REJECTS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (cmd_wr && sec.frozen && op_in == OP_UNLOCK) |=> state == ST_EXEC ##1 err)
      else $error("frozen card accepted unlock");
   AST_FROZEN_HOLDS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (sec.frozen && hw_sync) |=> sec.frozen)
      else $error("frozen state left without hardware reset");
   AST_FREEZE_RESULT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      take_freeze ##1 hw_sync |=> sec.frozen && frozen_o && !err && seccnt == 16'h0000)
      else $error("freeze lock did not freeze or zero sector count");
   AST_WEAR_LEVEL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (exec_ok && cmd.op == OP_FREEZE && cmd.wear) |=> wear_level_o && $stable(sec.frozen))
      else $error("unsupported freeze did not act as wear level");
   AST_USER_SET: assert property (@(posedge clk_i) disable iff (!rst_n_i || !hw_sync)
      load_user |=> sec.lock_en && sec.level_max == $past(cmd.level_max) && user_match)
      else $error("user password set did not arm locking");
   AST_MASTER_SET: assert property (@(posedge clk_i) disable iff (!rst_n_i || !hw_sync)
      load_master |=> $stable(sec.lock_en) && $stable(sec.level_max) && $stable(sec.locked))
      else $error("master password set changed lock state");
   AST_MAX_MASTER: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (exec_done && cmd.op == OP_UNLOCK && cmd.id_master && sec.level_max) |=> err)
      else $error("master unlock at maximum level not rejected");
   AST_MISMATCH_DEC: assert property (@(posedge clk_i) disable iff (!rst_n_i || !hw_sync)
      (exec_done && unlock_mis && !cmd.rej) |=> err && sec.tries == $past(sec.tries) - 3'h1)
      else $error("failed unlock did not decrement counter");
   AST_ZERO_ABORTS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (cmd_wr && op_in == OP_UNLOCK && sec.tries == 3'h0) |=> ##1 err)
      else $error("unlock accepted with counter at zero");
   AST_UNLOCKED_KEEPS: assert property (@(posedge clk_i) disable iff (!rst_n_i || !hw_sync)
      (exec_done && cmd.op == OP_UNLOCK && !sec.locked) |=> $stable(sec.tries))
      else $error("unlock on unlocked card changed counter");

   COV_UNLOCK_OK: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      exec_ok && cmd.op == OP_UNLOCK && sec.locked);
   COV_ERASE_OK: cover property (@(posedge clk_i) disable iff (!rst_n_i) erase_o);
   COV_TRIES_OUT: cover property (@(posedge clk_i) disable iff (!rst_n_i) sec.tries == 3'h0);
   COV_REFREEZE: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      take_freeze && sec.frozen);

endmodule // ssc_engine

// file: pkg/ssc_pkg.sv
// package: register map, opcodes, field layout and state types of the security command engine
package ssc_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // register bus shape
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;

   // register byte offsets, one aligned word each
   localparam logic [ADDR_W-1:0] ADDR_DATA = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_SECCNT = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_CMD_STAT = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_ERROR = 8'h0C;
   localparam logic [ADDR_W-1:0] ADDR_SECSTATE = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_CONFIG = 8'h14;

   ////////////////////////////////////////////////////////////////////////////////
   // command opcodes
   localparam logic [7:0] OP_SET_PW = 8'hF1;
   localparam logic [7:0] OP_UNLOCK = 8'hF2;
   localparam logic [7:0] OP_ERASE_PREP = 8'hF3;
   localparam logic [7:0] OP_ERASE_UNIT = 8'hF4;
   localparam logic [7:0] OP_FREEZE = 8'hF5;
   localparam logic [7:0] OP_DISABLE_PW = 8'hF6;

   ////////////////////////////////////////////////////////////////////////////////
   // password sector layout, in 16-bit words
   localparam int SECTOR_WORDS = 256;
   localparam int PW_FIRST_WORD = 1;
   localparam int PW_WORDS = 16;
   localparam int CTRL_ID_BIT = 0;
   localparam int CTRL_LEVEL_BIT = 8;

   // status, error and config bit positions
   localparam int STAT_BSY = 7;
   localparam int STAT_DRDY = 6;
   localparam int STAT_DRQ = 3;
   localparam int STAT_ERR = 0;
   localparam int ERR_ABRT = 2;
   localparam int CFG_SEC_BIT = 0;

   // values after reset
   localparam logic [2:0] UNLOCK_TRIES = 3'h5;
   localparam logic [DATA_W-1:0] SECCNT_RESET = 16'h0001;
   localparam logic [DATA_W-1:0] CONFIG_RESET = 16'h0001;

   ////////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_XFER = 2'b01,
      ST_EXEC = 2'b10
   } ssc_state_t;

   typedef struct packed {
      logic locked;
      logic frozen;
      logic lock_en;
      logic level_max;
      logic [2:0] tries;
   } ssc_sec_t;

   typedef struct packed {
      logic [7:0] op;
      logic id_master;
      logic level_max;
      logic rej;
      logic wear;
   } ssc_cmd_t;

   localparam ssc_sec_t SEC_RESET = '{locked: 1'b0, frozen: 1'b0, lock_en: 1'b0,
                                     level_max: 1'b0, tries: UNLOCK_TRIES};
   localparam ssc_cmd_t CMD_RESET = '{op: 8'h00, id_master: 1'b0, level_max: 1'b0,
                                     rej: 1'b0, wear: 1'b0};

endpackage

// file: logic/ssc_pw_slot.sv
// one stored password with its equality compare
`timescale 1ns/1ps
module ssc_pw_slot #(
   parameter int PW_BITS = 256
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic load_i,
   input wire logic [PW_BITS-1:0] pw_i,
   output logic match_o
);

   logic [PW_BITS-1:0] stored;

   if (PW_BITS < 8) begin : g_chk
      $error("ssc_pw_slot: password width too small");
   end

   // no nonvolatile store here: a power-on reset forgets the password
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stored <= '0;
      end else if (load_i) begin
         stored <= pw_i;
      end
   end

   // the same candidate bus feeds load and compare
   assign match_o = (stored == pw_i);

endmodule // ssc_pw_slot

// file: verification/ssc_host_model.sv
// host model: bus master that issues commands and sends the password sector
`timescale 1ns/1ps
module ssc_host_model import ssc_pkg::*; #(
   parameter int SW = 256
) (
   input wire logic clk_i,
   input wire logic busy_i,
   input wire logic drq_i,
   output logic [ADDR_W-1:0] addr_o,
   output logic [DATA_W-1:0] wdata_o,
   output logic we_o,
   output logic re_o
);
   ////////////////////////////////////////////////////////////////////////////////
   // idle bus at time zero
   initial begin
      addr_o = '0;
      wdata_o = '0;
      we_o = 1'b0;
      re_o = 1'b0;
   end
   // one strobe cycle, then a gap; data flips so a stale word never looks valid
   task automatic acc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic w);
      addr_o <= a;
      wdata_o <= d;
      we_o <= w;
      re_o <= !w;
      @(posedge clk_i);
      we_o <= 1'b0;
      re_o <= 1'b0;
      wdata_o <= ~d;
      @(posedge clk_i);
   endtask
   // command, then the sector only when the card asks for it
   task automatic cmd(input logic [7:0] op, input logic [15:0] ctl, input logic [255:0] pw);
      int n = 0;
      acc(ADDR_CMD_STAT, {8'h00, op}, 1'b1);
      if (drq_i) begin
         acc(ADDR_DATA, ctl, 1'b1);
         for (int i = 0; i < 16; i++) acc(ADDR_DATA, pw[16*i +: 16], 1'b1);
         for (int i = 17; i < SW; i++) acc(ADDR_DATA, 16'hA5C3, 1'b1);
      end
      while (busy_i && n < 40) begin
         @(posedge clk_i);
         n++;
      end
      @(posedge clk_i);
   endtask
endmodule // ssc_host_model

// file: verification/ssc_engine_test.sv
// self-checking bench for the security command engine
`timescale 1ns/1ps
module ssc_engine_test import ssc_pkg::*;;
   localparam logic [15:0] AB = 16'h0004;
   logic clk_i, rst_n_i, hw_rst_n_i, we_i, re_i, busy_o, drq_o, locked_o, frozen_o;
   logic erase_o, wear_level_o;
   logic re_d = 1'b0;
   logic [ADDR_W-1:0] addr_i;
   logic [DATA_W-1:0] wdata_i, rdata_o, r;
   logic [255:0] pu, pm;
   logic [15:0] exp_q[$];
   int err_count = 0, check_count = 0, n_erase = 0, n_wear = 0, seed = 58;
   ssc_engine #(.SECTOR_WORDS_P(17)) i_ssc_engine (.clk_i, .rst_n_i, .hw_rst_n_i, .addr_i,
      .wdata_i, .we_i, .re_i, .rdata_o, .busy_o, .drq_o, .locked_o, .frozen_o, .erase_o,
      .wear_level_o);
   ssc_host_model #(.SW(17)) i_ssc_host_model (.clk_i, .busy_i(busy_o), .drq_i(drq_o),
      .addr_o(addr_i), .wdata_o(wdata_i), .we_o(we_i), .re_o(re_i));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // read data stands only in the cycle after the strobe: pair it with the oldest note
   always @(posedge clk_i) begin
      if (re_d) chk("rdata", rdata_o, exp_q.pop_front());
      re_d <= re_i;
      n_erase <= n_erase + int'(erase_o);
      n_wear <= n_wear + int'(wear_level_o);
   end
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      i_ssc_host_model.acc(a, 16'h0000, 1'b0);
   endtask
   task automatic st(input logic [15:0] e, input logic [15:0] s);
      rd(ADDR_ERROR, e);
      rd(ADDR_SECSTATE, s);
   endtask
   task automatic cmd(input logic [7:0] op, input logic [15:0] c, input logic [255:0] p);
      i_ssc_host_model.cmd(op, c, p);
   endtask
   // pin reset held well past the two-flop synchroniser
   task automatic hwrst();
      hw_rst_n_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      hw_rst_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
   endtask
   task automatic test_done();
      if (err_count == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n_i = 1'b0;
      hw_rst_n_i = 1'b1;
      r = 16'($random(seed));
      for (int i = 0; i < 8; i++) begin
         pu[32*i +: 32] = $random(seed);
         pm[32*i +: 32] = $random(seed) ^ 32'h1;
      end
      repeat (8) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rd(ADDR_SECCNT, SECCNT_RESET);
      rd(8'h40, 16'h0000);
      st(16'h0000, 16'h0005);
      cmd(OP_ERASE_UNIT, 16'h0000, pu);
      st(AB, 16'h0005);
      cmd(OP_SET_PW, 16'h0000, pu);
      st(16'h0000, 16'h0015);
      cmd(OP_SET_PW, 16'h0001, pm);
      st(16'h0000, 16'h0015);
      hwrst();
      rd(ADDR_SECSTATE, 16'h0055);
      chk("locked", {15'h0, locked_o}, 16'h0001);
      cmd(OP_UNLOCK, 16'h0000, pm);
      st(AB, 16'h0054);
      cmd(OP_UNLOCK, 16'h0001, pm);
      st(16'h0000, 16'h0014);
      cmd(OP_UNLOCK, 16'h0000, pm);
      st(16'h0000, 16'h0014);
      cmd(OP_ERASE_PREP, 16'h0000, pu);
      cmd(OP_ERASE_UNIT, 16'h0000, pm);
      st(AB, 16'h0014);
      cmd(OP_ERASE_PREP, 16'h0000, pu);
      cmd(OP_ERASE_UNIT, 16'h0000, pu);
      st(16'h0000, 16'h0004);
      i_ssc_host_model.acc(ADDR_SECCNT, r, 1'b1);
      rd(ADDR_SECCNT, r);
      cmd(OP_FREEZE, 16'h0000, pu);
      chk("frozen", {15'h0, frozen_o}, 16'h0001);
      rd(ADDR_SECCNT, 16'h0000);
      cmd(OP_FREEZE, 16'h0000, pu);
      st(16'h0000, 16'h0024);
      cmd(OP_SET_PW, 16'h0000, pm);
      st(AB, 16'h0024);
      cmd(OP_UNLOCK, 16'h0000, pu);
      st(AB, 16'h0024);
      cmd(OP_DISABLE_PW, 16'h0000, pu);
      st(AB, 16'h0024);
      hwrst();
      rd(ADDR_SECSTATE, 16'h0005);
      cmd(OP_SET_PW, 16'h0100, pu);
      hwrst();
      rd(ADDR_SECSTATE, 16'h005D);
      cmd(OP_UNLOCK, 16'h0001, pm);
      st(AB, 16'h005D);
      repeat (5) cmd(OP_UNLOCK, 16'h0000, pm);
      st(AB, 16'h0058);
      cmd(OP_UNLOCK, 16'h0000, pu);
      st(AB, 16'h0058);
      cmd(OP_ERASE_PREP, 16'h0000, pu);
      cmd(OP_ERASE_UNIT, 16'h0000, pu);
      st(AB, 16'h0058);
      hwrst();
      cmd(OP_UNLOCK, 16'h0000, pu);
      st(16'h0000, 16'h001D);
      i_ssc_host_model.acc(ADDR_CONFIG, 16'h0000, 1'b1);
      rd(ADDR_CONFIG, 16'h0000);
      cmd(OP_FREEZE, 16'h0000, pu);
      // the pulse counter settles one edge after the pulse, so let it catch up
      repeat (2) @(posedge clk_i);
      chk("frozen", {15'h0, frozen_o}, 16'h0000);
      chk("wear", 16'(n_wear), 16'h0001);
      chk("erase", 16'(n_erase), 16'h0001);
      repeat (4) @(posedge clk_i);
      test_done();
   end
   // hang guard, far beyond the under one thousand cycles the sequence needs
   initial begin
      #100000;
      err_count++;
      test_done();
   end
endmodule // ssc_engine_test
